// ---- verilog/dcc_map.svh ----
// offsets, field positions, reset values and timing counts of the comparator control block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define DCC_OFS_CFG0        8'h00
`define DCC_OFS_CFG1        8'h04
`define DCC_OFS_STATUS      8'h08
`define DCC_OFS_MASK        8'h0c
`define DCC_OFS_AUX_PWR     8'h10

// ----------------------------------------------------------------------------
// configuration register fields (same layout for both comparators)
// ----------------------------------------------------------------------------
`define DCC_CFG_ENABLE      0
`define DCC_CFG_POS_SEL     1
`define DCC_CFG_NEG_REF     2
`define DCC_CFG_PIN_EN      3
`define DCC_CFG_OUT_BIT     4
`define DCC_CFG_INT_EN      5
`define DCC_CFG_FLAG        6
`define DCC_CFG_READY       7

// ----------------------------------------------------------------------------
// aux power control field
// ----------------------------------------------------------------------------
`define DCC_AUX_CMP_OFF     5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DCC_RST_CFG         8'h00
`define DCC_RST_AUX         8'h00
`define DCC_RST_DATA        32'h0000_0000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define DCC_CLK_KHZ         10000
`define DCC_SETTLE_US       10
`define DCC_SETTLE_CYC      ((`DCC_SETTLE_US * `DCC_CLK_KHZ + 999) / 1000)

`endif

// ---- verilog/dcc_pkg.sv ----
// types shared by the comparator control block
package dcc_pkg;

  // --------------------------------------------------------------------------
  // processor power modes as seen on power_mode_in
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_PM_RUN  = 2'b00,
    DCC_PM_IDLE = 2'b01,
    DCC_PM_PD   = 2'b10,
    DCC_PM_TPD  = 2'b11
  } dcc_pwr_mode_t;

  // --------------------------------------------------------------------------
  // per comparator enable sequencing
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_CH_OFF    = 2'b00,
    DCC_CH_SETTLE = 2'b01,
    DCC_CH_ON     = 2'b10
  } dcc_ch_state_t;

endpackage

// ---- verilog/dcc_channel.sv ----
// one comparator channel: output bit, disable forcing, change flag, settle tracking
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_channel (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  wire logic raw_in,
  input  wire logic flag_clr_in,
  output logic      out_bit_out,
  output logic      flag_out,
  output logic      ready_out
);

  dcc_pkg::dcc_ch_state_t state;
  dcc_pkg::dcc_ch_state_t next_state;
  logic [7:0]             cnt;
  logic [7:0]             next_cnt;
  logic                   next_out_bit;
  logic                   next_flag;

  // --------------------------------------------------------------------------
  // next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    // disabled comparator reads high
    next_out_bit = enable_in ? raw_in : 1'b1;                  // see RL1 see RL4
    // a change in the same cycle as a clear keeps the flag set
    if (next_out_bit != out_bit_out)
      next_flag = 1'b1;                                        // see RL7 see RL5
    else if (flag_clr_in)
      next_flag = 1'b0;                                        // see RL13
    else
      next_flag = flag_out;
    next_state = state;
    next_cnt   = cnt;
    case (state)
      dcc_pkg::DCC_CH_OFF:
      begin
        next_cnt = 8'h00;
        if (enable_in)
          next_state = dcc_pkg::DCC_CH_SETTLE;
      end
      dcc_pkg::DCC_CH_SETTLE:
      begin
        // ready only tells software the settle window is over; it gates nothing
        if (!enable_in)
          next_state = dcc_pkg::DCC_CH_OFF;
        else if (cnt == 8'(`DCC_SETTLE_CYC - 1))
          next_state = dcc_pkg::DCC_CH_ON;                     // see RL3
        else
          next_cnt = cnt + 8'h01;
      end
      dcc_pkg::DCC_CH_ON:
      begin
        if (!enable_in)
          next_state = dcc_pkg::DCC_CH_OFF;
      end
      default:
      begin
        next_state = dcc_pkg::DCC_CH_OFF;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state       <= dcc_pkg::DCC_CH_OFF;
      cnt         <= 8'h00;
      out_bit_out <= 1'b1;
      flag_out    <= 1'b0;
      ready_out   <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      out_bit_out <= next_out_bit;
      flag_out    <= next_flag;
      ready_out   <= (next_state == dcc_pkg::DCC_CH_ON);
    end
  end

endmodule // dcc_channel

// ---- verilog/dcc_power.sv ----
// power mode tracking: total power-down shutdown and wake request
`timescale 1ns/1ps

module dcc_power (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] power_mode_in,
  input  wire logic       irq_pend_in,
  output logic            tpd_out,
  output logic            wake_out
);

  logic next_tpd;
  logic next_wake;

  // --------------------------------------------------------------------------
  // next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_tpd  = (power_mode_in == dcc_pkg::DCC_PM_TPD);        // see RL10
    // no wake from total power-down: the comparators are off there anyway
    next_wake = irq_pend_in &&
                ((power_mode_in == dcc_pkg::DCC_PM_IDLE) ||
                 (power_mode_in == dcc_pkg::DCC_PM_PD));       // see RL11
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tpd_out  <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      tpd_out  <= next_tpd;
      wake_out <= next_wake;
    end
  end

endmodule // dcc_power

// ---- verilog/dcc_top.sv ----
// dual comparator control: register slave, input steering, flags, interrupt and wake
//
// Notes on behaviour
// RL1: output bit is one when positive input exceeds negative; readable, optional pin.
// RL2: positive input picks one of two pins; negative picks pin or reference.
// RL3: software waits ten microseconds after enable, then clears flag before interrupt.
// RL4: a disabled comparator forces its output bit high.
// RL5: forced low-to-high on disable sets the change flag and may interrupt.
// RL6: software masks interrupt before disabling, clears flag afterwards.
// RL7: each change of output, either way, sets that comparator's change flag.
// RL8: each comparator has its own interrupt enable; flag is pollable regardless.
// RL9: both comparators share one interrupt; handler reads both flags.
// RL10: comparators keep running in idle and power-down, off in total power-down.
// RL11: enabled change interrupt wakes from idle or power-down, not total power-down.
// RL12: bit five of aux power control switches both comparators off.
// RL13: change flag stays set until written zero; clearing withdraws its request. Code also clears it on a one written to its STATUS bit.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // classic wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // analog front end
  input  wire logic [1:0]  cmp_raw_in,
  output logic      [1:0]  ana_enable_out,
  output logic      [1:0]  ana_pos_sel_out,
  output logic      [1:0]  ana_neg_ref_out,
  // comparator output pins
  output logic      [1:0]  cmp_pin_out,
  output logic      [1:0]  cmp_pin_oe_out,
  // processor side
  input  wire logic [1:0]  power_mode_in,
  output logic             irq_out,
  output logic             wake_out
);

  // --------------------------------------------------------------------------
  // software state
  // --------------------------------------------------------------------------
  logic [1:0]  cfg_enable;
  logic [1:0]  cfg_pos_sel;
  logic [1:0]  cfg_neg_ref;
  logic [1:0]  cfg_pin_en;
  logic [1:0]  cfg_int_en;
  logic        aux_cmp_off;
  logic [1:0]  next_cfg_enable;
  logic [1:0]  next_cfg_pos_sel;
  logic [1:0]  next_cfg_neg_ref;
  logic [1:0]  next_cfg_pin_en;
  logic [1:0]  next_cfg_int_en;
  logic        next_aux_cmp_off;

  // reset words are kept whole so that the field positions pick their bits
  localparam logic [7:0] RST_CFG = `DCC_RST_CFG;
  localparam logic [7:0] RST_AUX = `DCC_RST_AUX;

  // bus
  logic        next_ack;
  logic [31:0] next_dat;
  logic        wr_stb;
  logic        wr_lane0;
  logic        cfg_idx;

  // channel signals
  logic [1:0]  run_enable;
  logic [1:0]  out_bit;
  logic [1:0]  flag;
  logic [1:0]  ready;
  logic [1:0]  flag_clr;
  logic        tpd;
  logic        irq_pend;

  // outputs
  logic [1:0]  next_ana_enable;
  logic [1:0]  next_ana_pos_sel;
  logic [1:0]  next_ana_neg_ref;
  logic [1:0]  next_pin;
  logic [1:0]  next_pin_oe;
  logic        next_irq;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // a write lands on the edge at which the master sees ack, never earlier
  assign wr_stb   = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
  assign wr_lane0 = wr_stb && wb_sel_in[0];

  // both configuration registers share one layout; address bit 2 picks the channel
  assign cfg_idx  = wb_adr_in[2];

  // builds the readable byte of one configuration register
  function automatic logic [7:0] cfg_byte(input logic [1:0] idx);
    logic [7:0] b;
    b                   = 8'h00;

    b[`DCC_CFG_ENABLE]  = cfg_enable[idx[0]];
    b[`DCC_CFG_POS_SEL] = cfg_pos_sel[idx[0]];
    b[`DCC_CFG_NEG_REF] = cfg_neg_ref[idx[0]];
    b[`DCC_CFG_PIN_EN]  = cfg_pin_en[idx[0]];
    b[`DCC_CFG_OUT_BIT] = out_bit[idx[0]];
    b[`DCC_CFG_INT_EN]  = cfg_int_en[idx[0]];
    b[`DCC_CFG_FLAG]    = flag[idx[0]];
    b[`DCC_CFG_READY]   = ready[idx[0]];
    return b;
  endfunction

  // --------------------------------------------------------------------------
  // bus next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    // one-cycle ack: a master still holding stb is not answered on two cycles in a row
    next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
    next_dat = `DCC_RST_DATA;

    if (next_ack && !wb_we_in)
    begin
      case (wb_adr_in)
        `DCC_OFS_CFG0:    next_dat[7:0] = cfg_byte(2'h0);          // see RL1
        `DCC_OFS_CFG1:    next_dat[7:0] = cfg_byte(2'h1);
        `DCC_OFS_STATUS:  next_dat[1:0] = flag;                    // see RL9
        `DCC_OFS_MASK:    next_dat[1:0] = cfg_int_en;
        `DCC_OFS_AUX_PWR: next_dat[`DCC_AUX_CMP_OFF] = aux_cmp_off;
        default:          next_dat = `DCC_RST_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= `DCC_RST_DATA;
    end
    else
    begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end

  // --------------------------------------------------------------------------
  // configuration next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_cfg_enable  = cfg_enable;
    next_cfg_pos_sel = cfg_pos_sel;
    next_cfg_neg_ref = cfg_neg_ref;
    next_cfg_pin_en  = cfg_pin_en;
    next_cfg_int_en  = cfg_int_en;
    next_aux_cmp_off = aux_cmp_off;

    flag_clr         = 2'b00;
    if (wr_lane0)
    begin
      case (wb_adr_in)
        `DCC_OFS_CFG0, `DCC_OFS_CFG1:
        begin
          // output and settled bits are read-only and ignore the write
          next_cfg_enable[cfg_idx]  = wb_dat_in[`DCC_CFG_ENABLE];
          next_cfg_pos_sel[cfg_idx] = wb_dat_in[`DCC_CFG_POS_SEL]; // see RL2
          next_cfg_neg_ref[cfg_idx] = wb_dat_in[`DCC_CFG_NEG_REF]; // see RL2
          next_cfg_pin_en[cfg_idx]  = wb_dat_in[`DCC_CFG_PIN_EN];
          next_cfg_int_en[cfg_idx]  = wb_dat_in[`DCC_CFG_INT_EN];  // see RL8
          // writing a zero clears; writing a one leaves the flag alone
          flag_clr[cfg_idx]         = !wb_dat_in[`DCC_CFG_FLAG];   // see RL13
        end

        `DCC_OFS_STATUS:
        begin
          // a handler clears the flags it has read by writing ones here
          flag_clr = wb_dat_in[1:0];                                    // see RL13
        end

        `DCC_OFS_MASK:
        begin
          next_cfg_int_en = wb_dat_in[1:0];                             // see RL8
        end

        `DCC_OFS_AUX_PWR:
        begin
          // enable bits survive; only the running comparators stop
          next_aux_cmp_off = wb_dat_in[`DCC_AUX_CMP_OFF];               // see RL12
        end

        default:
        begin
          flag_clr = 2'b00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_enable  <= {2{RST_CFG[`DCC_CFG_ENABLE]}};
      cfg_pos_sel <= {2{RST_CFG[`DCC_CFG_POS_SEL]}};
      cfg_neg_ref <= {2{RST_CFG[`DCC_CFG_NEG_REF]}};
      cfg_pin_en  <= {2{RST_CFG[`DCC_CFG_PIN_EN]}};
      cfg_int_en  <= {2{RST_CFG[`DCC_CFG_INT_EN]}};
      aux_cmp_off <= RST_AUX[`DCC_AUX_CMP_OFF];
    end
    else
    begin
      cfg_enable  <= next_cfg_enable;
      cfg_pos_sel <= next_cfg_pos_sel;
      cfg_neg_ref <= next_cfg_neg_ref;
      cfg_pin_en  <= next_cfg_pin_en;
      cfg_int_en  <= next_cfg_int_en;
      aux_cmp_off <= next_aux_cmp_off;
    end
  end

  // --------------------------------------------------------------------------
  // comparator channels
  // --------------------------------------------------------------------------
  // the enable bit itself is kept, so a comparator shut by total power-down
  // comes back by itself when the mode is left
  assign run_enable = cfg_enable & {2{!aux_cmp_off && !tpd}};  // see RL10 see RL12

  // one instance per comparator; they share nothing but clock and reset
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ch
      dcc_channel u_ch (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .enable_in   (run_enable[gi]),
        .raw_in      (cmp_raw_in[gi]),
        .flag_clr_in (flag_clr[gi]),
        .out_bit_out (out_bit[gi]),
        .flag_out    (flag[gi]),
        .ready_out   (ready[gi])
      );
    end
  endgenerate

  // one shared request; a cleared flag drops out of it at once
  assign irq_pend = |(flag & cfg_int_en);                      // see RL9 see RL13

  // wake is only asked for while the processor sleeps lightly
  dcc_power u_power (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .power_mode_in (power_mode_in),
    .irq_pend_in   (irq_pend),
    .tpd_out       (tpd),
    .wake_out      (wake_out)
  );

  // --------------------------------------------------------------------------
  // pin and interrupt next values
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_ana_enable  = run_enable;
    next_ana_pos_sel = cfg_pos_sel;                            // see RL2
    next_ana_neg_ref = cfg_neg_ref;                            // see RL2
    next_pin         = out_bit;                                // see RL1
    next_pin_oe      = cfg_pin_en;

    next_irq         = irq_pend;                               // see RL8 see RL5
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ana_enable_out  <= 2'b00;
      ana_pos_sel_out <= 2'b00;
      ana_neg_ref_out <= 2'b00;
      cmp_pin_out     <= 2'b11;
      cmp_pin_oe_out  <= 2'b00;
      irq_out         <= 1'b0;
    end
    else
    begin
      ana_enable_out  <= next_ana_enable;
      ana_pos_sel_out <= next_ana_pos_sel;
      ana_neg_ref_out <= next_ana_neg_ref;
      cmp_pin_out     <= next_pin;
      cmp_pin_oe_out  <= next_pin_oe;
      irq_out         <= next_irq;
    end
  end

endmodule // dcc_top

// ---- verification/dcc_top_sva.sv ----
// assertion checker for the dual comparator control block
`timescale 1ns/1ps

module dcc_top_sva (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  input  wire logic [1:0]  cmp_raw_in,
  input  wire logic [1:0]  ana_enable_out,
  input  wire logic [1:0]  cmp_pin_out,
  input  wire logic [1:0]  power_mode_in,
  input  wire logic        irq_out,
  input  wire logic        wake_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ---------------------------------------------------------------
  // bus sequences and properties
  // ---------------------------------------------------------------
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  property p_ack_pulse;
    s_req |=> s_ack_pulse;
  endproperty
  property p_ack_cause;
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  property p_dat_idle;
    !wb_ack_out |-> wb_dat_out == 32'h0;
  endproperty
  property p_dat_upper;
    wb_ack_out |-> wb_dat_out[31:8] == 24'h0;
  endproperty

  // ---------------------------------------------------------------
  // comparator path, interrupt and wake
  // ---------------------------------------------------------------
  property p_pin_follow;
    ana_enable_out[0] |=> cmp_pin_out[0] == $past(cmp_raw_in[0], 2);
  endproperty
  // a switched-off channel must read high one cycle after its enable drops
  property p_pin_forced;
    1'b1 |=> &(cmp_pin_out | $past(ana_enable_out));
  endproperty
  property p_tpd_off;
    (power_mode_in == dcc_pkg::DCC_PM_TPD) [*3] |-> ana_enable_out == 2'h0;
  endproperty
  property p_wake_gate;
    wake_out |-> irq_out && $past(power_mode_in) inside {2'h1, 2'h2};
  endproperty
  property p_wake_rise;
    (irq_out && power_mode_in == dcc_pkg::DCC_PM_IDLE) [*2] |-> wake_out;
  endproperty
  // the shared request only drops after a software write
  property p_irq_clear;
    $fell(irq_out) |-> $past(wb_ack_out && wb_we_in, 2);
  endproperty

  a_ack_pulse:  assert property (p_ack_pulse)  else $error("ack not a single pulse");
  a_ack_cause:  assert property (p_ack_cause)  else $error("ack without request");
  a_dat_idle:   assert property (p_dat_idle)   else $error("read data outside ack");
  a_dat_upper:  assert property (p_dat_upper)  else $error("upper read bytes not zero");
  a_pin_follow: assert property (p_pin_follow) else $error("pin not raw result");
  a_pin_forced: assert property (p_pin_forced) else $error("disabled pin not high");
  a_tpd_off:    assert property (p_tpd_off)    else $error("enable kept in deep sleep");
  a_wake_gate:  assert property (p_wake_gate)  else $error("wake in wrong mode");
  a_wake_rise:  assert property (p_wake_rise)  else $error("no wake on irq in idle");
  a_irq_clear:  assert property (p_irq_clear)  else $error("irq dropped by itself");
endmodule // dcc_top_sva

// ---- verification/dcc_analog_model.sv ----
// behavioural analog front end: pin levels, reference and two comparators
`timescale 1ns/1ps

module dcc_analog_model #(
  parameter logic [7:0] VREF = 8'h7b
) (
  input  wire logic        clk_in,
  input  wire logic [1:0]  ana_enable_in,
  input  wire logic [1:0]  ana_pos_sel_in,
  input  wire logic [1:0]  ana_neg_ref_in,
  input  wire logic [15:0] pin_a_in,
  input  wire logic [15:0] pin_b_in,
  input  wire logic [15:0] pin_n_in,
  output logic      [1:0]  cmp_raw_out
);
  logic [7:0] pos;
  logic [7:0] neg;

  initial cmp_raw_out = 2'h0;
  // an unpowered comparator has no valid answer, so it shows a moving pattern
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      pos = ana_pos_sel_in[i] ? pin_b_in[8*i +: 8] : pin_a_in[8*i +: 8];
      neg = ana_neg_ref_in[i] ? VREF : pin_n_in[8*i +: 8];
      cmp_raw_out[i] <= ana_enable_in[i] ? (pos > neg) : ~cmp_raw_out[i];
    end
  end
endmodule // dcc_analog_model

// ---- verification/dcc_top_bench.sv ----
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_top_bench;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wb_cyc_in = 1'b0;
  logic        wb_stb_in = 1'b0;
  logic        wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h0;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [1:0]  power_mode_in = 2'h0;
  logic [15:0] pa = 16'h5070;
  logic [15:0] pb = 16'h0090;
  logic [15:0] pn = 16'h0060;
  logic [3:0]  lane = 4'hf;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out, irq_out, wake_out;
  logic [1:0]  cmp_raw_in, ana_enable_out, ana_pos_sel_out, ana_neg_ref_out;
  logic [1:0]  cmp_pin_out, cmp_pin_oe_out;
  int          n_fail = 0;
  int          check_count = 0;

  always #50 clk_in = ~clk_in;

  dcc_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .cmp_raw_in(cmp_raw_in), .ana_enable_out(ana_enable_out),
    .ana_pos_sel_out(ana_pos_sel_out), .ana_neg_ref_out(ana_neg_ref_out),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_out(cmp_pin_oe_out),
    .power_mode_in(power_mode_in), .irq_out(irq_out), .wake_out(wake_out));

  dcc_analog_model ana (.clk_in(clk_in), .ana_enable_in(ana_enable_out),
    .ana_pos_sel_in(ana_pos_sel_out), .ana_neg_ref_in(ana_neg_ref_out),
    .pin_a_in(pa), .pin_b_in(pb), .pin_n_in(pn), .cmp_raw_out(cmp_raw_in));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // idle gap after each access lets the analog path and flags settle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_sel_in <= lane;
    wb_dat_in <= d;
    @(posedge clk_in);
    while (wb_ack_out !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      n++;
    end
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n == 20)
    begin
      n_fail++;
      end_of_test();
    end
    repeat (4) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wait_ready(input logic [7:0] a);
    logic [31:0] q;
    int n;
    q = 32'h0;
    for (n = 0; n < 40 && q[`DCC_CFG_READY] !== 1'b1; n++)
      xfer(1'b0, a, 32'h0, q);
    if (n == 40)
    begin
      n_fail++;
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(`DCC_OFS_CFG0, 32'h10);
    rdc(`DCC_OFS_CFG1, 32'h10);
    rdc(`DCC_OFS_STATUS, 32'h0);
    rdc(`DCC_OFS_MASK, 32'h0);
    rdc(`DCC_OFS_AUX_PWR, 32'h0);
    rdc(8'h14, 32'h0);
    chk(32'(cmp_pin_out), 32'h3);
    $display("reset values done");
    // settle wait and flag clear before any interrupt use
    wr(`DCC_OFS_CFG0, 32'h09);
    wait_ready(`DCC_OFS_CFG0);
    wr(`DCC_OFS_CFG0, 32'h09);
    rdc(`DCC_OFS_CFG0, 32'h99);
    chk(32'(cmp_pin_oe_out), 32'h1);
    wr(`DCC_OFS_CFG0, 32'h0d);
    rdc(`DCC_OFS_CFG0, 32'hcd);
    chk(32'(irq_out), 32'h0);
    wr(`DCC_OFS_STATUS, 32'h1);
    rdc(`DCC_OFS_STATUS, 32'h0);
    wr(`DCC_OFS_CFG0, 32'h0f);
    rdc(`DCC_OFS_CFG0, 32'hdf);
    rdc(`DCC_OFS_STATUS, 32'h1);
    chk(32'({ana_pos_sel_out, ana_neg_ref_out}), 32'h5);
    $display("input selection done");
    wr(`DCC_OFS_STATUS, 32'h1);
    wr(`DCC_OFS_MASK, 32'h1);
    chk(32'(irq_out), 32'h0);
    pb <= 16'h0050;
    repeat (6) @(posedge clk_in);
    chk(32'(irq_out), 32'h1);
    rdc(`DCC_OFS_STATUS, 32'h1);
    wr(`DCC_OFS_CFG0, 32'h2f);
    chk(32'(irq_out), 32'h0);
    $display("interrupt done");
    // disabling a low output raises the flag, then software tidies up
    wr(`DCC_OFS_CFG0, 32'h2e);
    rdc(`DCC_OFS_CFG0, 32'h7e);
    chk(32'(irq_out), 32'h1);
    chk(32'(ana_enable_out), 32'h0);
    wr(`DCC_OFS_MASK, 32'h0);
    wr(`DCC_OFS_STATUS, 32'h1);
    chk(32'(irq_out), 32'h0);
    $display("disable done");
    wr(`DCC_OFS_CFG1, 32'h05);
    wait_ready(`DCC_OFS_CFG1);
    wr(`DCC_OFS_STATUS, 32'h2);
    wr(`DCC_OFS_MASK, 32'h2);
    power_mode_in <= dcc_pkg::DCC_PM_IDLE;
    pa <= 16'h9070;
    repeat (6) @(posedge clk_in);
    chk(32'({irq_out, wake_out}), 32'h3);
    rdc(`DCC_OFS_STATUS, 32'h2);
    wr(`DCC_OFS_STATUS, 32'h2);
    chk(32'({irq_out, wake_out}), 32'h0);
    power_mode_in <= dcc_pkg::DCC_PM_PD;
    pa <= 16'h5070;
    repeat (6) @(posedge clk_in);
    chk(32'({irq_out, wake_out}), 32'h3);
    wr(`DCC_OFS_STATUS, 32'h2);
    power_mode_in <= dcc_pkg::DCC_PM_TPD;
    repeat (6) @(posedge clk_in);
    chk(32'(ana_enable_out), 32'h0);
    chk(32'({irq_out, wake_out}), 32'h2);
    chk(32'(cmp_pin_out[1]), 32'h1);
    power_mode_in <= dcc_pkg::DCC_PM_RUN;
    wr(`DCC_OFS_MASK, 32'h0);
    wr(`DCC_OFS_STATUS, 32'h2);
    chk(32'(ana_enable_out), 32'h2);
    $display("power modes done");
    wr(`DCC_OFS_AUX_PWR, 32'h20);
    chk(32'(ana_enable_out), 32'h0);
    rdc(`DCC_OFS_AUX_PWR, 32'h20);
    rdc(`DCC_OFS_STATUS, 32'h2);
    chk(32'(irq_out), 32'h0);
    wr(`DCC_OFS_AUX_PWR, 32'h0);
    chk(32'(ana_enable_out), 32'h2);
    lane = 4'he;
    wr(`DCC_OFS_AUX_PWR, 32'h20);
    lane = 4'hf;
    rdc(`DCC_OFS_AUX_PWR, 32'h0);
    $display("aux power done");
    end_of_test();
  end
endmodule // dcc_top_bench

bind dcc_top dcc_top_sva chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .cmp_raw_in(cmp_raw_in),
  .ana_enable_out(ana_enable_out), .cmp_pin_out(cmp_pin_out),
  .power_mode_in(power_mode_in), .irq_out(irq_out), .wake_out(wake_out));
